// ==== core/irqev_pkg.sv ====
// shared constants and types for the event and channel enable block
package irqev_pkg;

    // register byte offsets on the host bus
    localparam logic [7:0] OFS_CHAN_SET = 8'h78;
    localparam logic [7:0] OFS_CHAN_CLR = 8'h7C;
    localparam logic [7:0] OFS_EV_SET = 8'h80;
    localparam logic [7:0] OFS_EV_CLR = 8'h84;
    localparam logic [7:0] OFS_LINK_CTRL = 8'h88;
    localparam logic [7:0] OFS_EV_RAW = 8'h8C;

    // event bit positions
    localparam int EV_CTX0 = 0;
    localparam int EV_RQ_PKT = 4;
    localparam int EV_RS_PKT = 5;
    localparam int EV_ISO_TX = 6;
    localparam int EV_ISO_RX = 7;
    localparam int EV_POST_WR = 8;
    localparam int EV_LOCK_RESP = 9;
    localparam int EV_SELFID = 16;
    localparam int EV_BUSRST = 17;
    localparam int EV_PHY = 19;
    localparam int EV_SYNCH = 20;
    localparam int EV_SEC64 = 21;
    localparam int EV_LOST = 22;
    localparam int EV_MISMATCH = 23;
    localparam int EV_FATAL = 24;
    localparam int EV_OVERLONG = 25;
    localparam int EV_PHYREG = 26;
    localparam int EV_GP = 30;

    // latched positions; reserved and summary bits stay zero
    localparam logic [31:0] EV_LATCH_MASK = 32'h47FB033F;

    // link control fields
    localparam int LC_GP_A_EN = 0;
    localparam int LC_GP_B_EN = 1;
    localparam int LC_ROOT_EN = 21;
    localparam logic [31:0] LC_WRITE_MASK = 32'h00200003;
    localparam logic [31:0] LC_RESET = 32'h00000000;
    localparam logic [31:0] CHAN_RESET = 32'h00000000;
    localparam logic [31:0] EV_RESET = 32'h00000000;

    // overlong cycle limit
    localparam int CLK_MHZ = 40;
    localparam int OVERLONG_US = 125;
    localparam int OVERLONG_CYCLES = OVERLONG_US * CLK_MHZ;

    // cycle timer word
    typedef struct packed {
        logic [6:0] seconds;
        logic [12:0] count;
        logic [11:0] offset;
    } irqev_timer_t;

endpackage : irqev_pkg

// ==== core/irqev_core.sv ====
// event register, channel enable register and their bus slave
`timescale 1ns/1ps

// Functional notes
// [R1] channel enable bit n admits iso channel n
// [R2] channel enable: set and clear addresses
// [R3] event sets on rising source or set-write
// [R4] events other than bit 16 clear only by clear-address write
// [R5] event read returns events AND mask
// [R6] reserved event bits read zero, ignore writes
// [R7] bit 30 from enabled general-purpose inputs
// [R8] bit 26 when physical register byte arrives
// [R9] bit 25 on cycle over 125 us
// [R10] overlong cycle clears root timing enable
// [R11] bit 24 when any subunit halts
// [R12] fatal bit blocks halted contexts' events
// [R13] bit 23 on received cycle value mismatch
// [R14] bit 22 when cycle start missing
// [R15] bit 22 may be set on prediction
// [R16] bit 21 when seconds bit six changes
// [R17] bit 20 when count low bit toggles
// [R18] bit 19 on physical layer interrupt status
// [R19] bit 16 clears as bit 17 sets
// [R20] bits 7 and 6 live masked summaries
// [R21] zero written to set/clear changes nothing
// [R22] hardware set beats simultaneous software clear
module irqev_core #(
    parameter int NUM_CTX = 4,
    parameter int ISO_CTX = 4,
    parameter int OVERLONG_CYCLES = irqev_pkg::OVERLONG_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // interrupt mask held elsewhere
    input wire logic [31:0] int_mask_in,
    // event sources, levels, rising edge counts
    input wire logic gp_input_a_in,
    input wire logic gp_input_b_in,
    input wire logic phys_reg_byte_arrived_in,
    input wire logic phy_status_irq_in,
    input wire logic serial_bus_reset_in,
    input wire logic node_id_phase_done_in,
    input wire logic [NUM_CTX-1:0] ctx_dead_in,
    input wire logic [NUM_CTX-1:0] ctx_event_in,
    input wire logic [3:0] misc_event_in,
    // cycle timing
    input wire irqev_pkg::irqev_timer_t cycle_timer_in,
    input wire irqev_pkg::irqev_timer_t rx_stamp_in,
    input wire logic rx_cycle_start_in,
    input wire logic tx_cycle_start_in,
    input wire logic subaction_gap_in,
    input wire logic arb_reset_gap_in,
    // isochronous context summaries
    input wire logic [ISO_CTX-1:0] iso_rx_ctx_event_in,
    input wire logic [ISO_CTX-1:0] iso_rx_ctx_mask_in,
    input wire logic [ISO_CTX-1:0] iso_tx_ctx_event_in,
    input wire logic [ISO_CTX-1:0] iso_tx_ctx_mask_in,
    // iso receive channel filter
    input wire logic rx_iso_valid_in,
    input wire logic [5:0] rx_iso_chan_in,
    output logic rx_iso_accept_out,
    // state out
    output logic [31:0] iso_rx_chan_enable_out,
    output logic [31:0] int_event_out,
    output logic root_timing_source_enable_out
);

    // contexts map onto event bits 0 up to the packet bits
    initial begin
        if (NUM_CTX < 1 || NUM_CTX > 4) begin
            $error("NUM_CTX must be 1 to 4");
        end
        if (ISO_CTX < 1 || ISO_CTX > 32) begin
            $error("ISO_CTX must be 1 to 32");
        end
        if (OVERLONG_CYCLES < 1 || OVERLONG_CYCLES > 65534) begin
            $error("OVERLONG_CYCLES out of range");
        end
    end

    localparam logic [15:0] OVERLONG_LIMIT = 16'(OVERLONG_CYCLES);

    // byte enables widened to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    // ones written in enabled lanes
    function automatic logic [31:0] lane_ones(input logic [31:0] data,
                                              input logic [3:0] be);
        lane_ones = data & be_mask(be);
    endfunction : lane_ones

    logic [31:0] chan_enable;
    logic [31:0] ev;
    logic [31:0] link_ctrl;
    logic [31:0] hw_set;
    logic [31:0] hw_clr;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] next_ev;
    logic [31:0] read_value;
    logic wr_accept;
    logic [31:0] wr_bits;

    // previous levels for edge detection
    logic gp_a_q, gp_b_q, phyreg_q, phy_q, busrst_q, selfid_q;
    logic rx_cs_q, tx_cs_q, gap_q, arb_q;
    logic [NUM_CTX-1:0] dead_q;
    logic [NUM_CTX-1:0] ctx_q;
    logic [3:0] misc_q;
    logic [NUM_CTX-1:0] dead_cause;

    // cycle tracking state
    logic sec6_q, cnt0_q, timer_valid;
    logic overlong_run;
    logic [15:0] overlong_cnt;
    logic seen_start, sync_armed, gap_seen, loss_flagged;

    wire logic rx_cs_rise = rx_cycle_start_in & ~rx_cs_q;
    wire logic tx_cs_rise = tx_cycle_start_in & ~tx_cs_q;
    wire logic gap_rise = subaction_gap_in & ~gap_q;
    wire logic arb_rise = arb_reset_gap_in & ~arb_q;
    wire logic cs_any = rx_cs_rise | tx_cs_rise;
    wire logic synch = timer_valid &
        (cycle_timer_in.count[0] != cnt0_q);
    wire logic sec6_flip = timer_valid &
        (cycle_timer_in.seconds[6] != sec6_q);
    wire logic overlong_hit = overlong_run & ~gap_rise &
        (overlong_cnt == OVERLONG_LIMIT);
    wire logic lost_now = sync_armed & ~seen_start & ~loss_flagged & synch;
    wire logic lost_guess = sync_armed & ~seen_start & ~loss_flagged &
        (arb_rise | (gap_rise & gap_seen));

    assign wr_accept = avs_write_in & ~avs_waitrequest_out;
    assign wr_bits = lane_ones(avs_writedata_in, avs_byteenable_in);

    // software set and clear strobes; zeros leave bits alone
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_accept && avs_address_in == irqev_pkg::OFS_EV_SET) begin
            sw_set = wr_bits & irqev_pkg::EV_LATCH_MASK; // [R3] [R6] [R21]
        end
        if (wr_accept && avs_address_in == irqev_pkg::OFS_EV_CLR) begin
            sw_clr = wr_bits & irqev_pkg::EV_LATCH_MASK; // [R4] [R6] [R21]
        end
    end

    // context events, held off while their halt is being reported
    logic [NUM_CTX-1:0] ctx_set;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CTX; gi++) begin : g_ctx
            assign ctx_set[gi] = ctx_event_in[gi] & ~ctx_q[gi] &
                ~(ev[irqev_pkg::EV_FATAL] & dead_cause[gi]); // [R12]
        end
    endgenerate

    // hardware set sources
    always_comb begin
        hw_set = '0;
        hw_set[irqev_pkg::EV_CTX0 +: NUM_CTX] = ctx_set;
        hw_set[irqev_pkg::EV_RQ_PKT] = misc_event_in[0] & ~misc_q[0];
        hw_set[irqev_pkg::EV_RS_PKT] = misc_event_in[1] & ~misc_q[1];
        hw_set[irqev_pkg::EV_POST_WR] = misc_event_in[2] & ~misc_q[2];
        hw_set[irqev_pkg::EV_LOCK_RESP] = misc_event_in[3] & ~misc_q[3];
        hw_set[irqev_pkg::EV_SELFID] =
            node_id_phase_done_in & ~selfid_q;
        hw_set[irqev_pkg::EV_BUSRST] = serial_bus_reset_in & ~busrst_q;
        hw_set[irqev_pkg::EV_PHY] = phy_status_irq_in & ~phy_q; // [R18]
        hw_set[irqev_pkg::EV_SYNCH] = synch; // [R17]
        hw_set[irqev_pkg::EV_SEC64] = sec6_flip; // [R16]
        hw_set[irqev_pkg::EV_LOST] = lost_now | lost_guess; // [R14] [R15]
        hw_set[irqev_pkg::EV_MISMATCH] = rx_cs_rise &
            ((rx_stamp_in.seconds != cycle_timer_in.seconds) |
             (rx_stamp_in.count != cycle_timer_in.count)); // [R13]
        hw_set[irqev_pkg::EV_FATAL] = |(ctx_dead_in & ~dead_q); // [R11]
        hw_set[irqev_pkg::EV_OVERLONG] = overlong_hit; // [R9]
        hw_set[irqev_pkg::EV_PHYREG] =
            phys_reg_byte_arrived_in & ~phyreg_q; // [R8]
        hw_set[irqev_pkg::EV_GP] =
            (gp_input_a_in & ~gp_a_q & link_ctrl[irqev_pkg::LC_GP_A_EN]) |
            (gp_input_b_in & ~gp_b_q &
             link_ctrl[irqev_pkg::LC_GP_B_EN]); // [R7]
    end

    // bus reset knocks out the node id phase bit as it rises
    always_comb begin
        hw_clr = '0;
        hw_clr[irqev_pkg::EV_SELFID] =
            (hw_set[irqev_pkg::EV_BUSRST] | sw_set[irqev_pkg::EV_BUSRST]) &
            ~ev[irqev_pkg::EV_BUSRST]; // [R19]
    end

    // set wins over software clear so a coincident event is kept; a bus reset rise still drops a coincident bit 16 set
    always_comb begin
        next_ev = (ev | hw_set | sw_set) & ~(sw_clr & ~hw_set); // [R3] [R22]
        next_ev = next_ev & ~hw_clr; // [R19]
        next_ev = next_ev & irqev_pkg::EV_LATCH_MASK; // [R6]
    end

    // latched event register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ev <= irqev_pkg::EV_RESET;
        end else begin
            ev <= next_ev; // [R4]
        end
    end

    // channel enable set/clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            chan_enable <= irqev_pkg::CHAN_RESET;
        end else if (wr_accept) begin
            if (avs_address_in == irqev_pkg::OFS_CHAN_SET) begin
                chan_enable <= chan_enable | wr_bits; // [R2] [R21]
            end else if (avs_address_in == irqev_pkg::OFS_CHAN_CLR) begin
                chan_enable <= chan_enable & ~wr_bits; // [R2] [R21]
            end
        end
    end

    // link control; overlong cycle drops root timing over any write
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            link_ctrl <= irqev_pkg::LC_RESET;
        end else begin
            if (wr_accept && avs_address_in == irqev_pkg::OFS_LINK_CTRL) begin
                link_ctrl <= (link_ctrl & ~be_mask(avs_byteenable_in)) |
                    (wr_bits & irqev_pkg::LC_WRITE_MASK);
            end
            if (overlong_hit) begin
                link_ctrl[irqev_pkg::LC_ROOT_EN] <= 1'b0; // [R10]
            end
        end
    end

    // source edge history
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            {gp_a_q, gp_b_q, phyreg_q, phy_q, busrst_q, selfid_q} <= '0;
            {rx_cs_q, tx_cs_q, gap_q, arb_q} <= '0;
            dead_q <= '0;
            ctx_q <= '0;
            misc_q <= '0;
        end else begin
            gp_a_q <= gp_input_a_in;
            gp_b_q <= gp_input_b_in;
            phyreg_q <= phys_reg_byte_arrived_in;
            phy_q <= phy_status_irq_in;
            busrst_q <= serial_bus_reset_in;
            selfid_q <= node_id_phase_done_in;
            rx_cs_q <= rx_cycle_start_in;
            tx_cs_q <= tx_cycle_start_in;
            gap_q <= subaction_gap_in;
            arb_q <= arb_reset_gap_in;
            dead_q <= ctx_dead_in;
            ctx_q <= ctx_event_in;
            misc_q <= misc_event_in;
        end
    end

    // remember which contexts halted until the fatal bit is cleared
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            dead_cause <= '0;
        end else if (!next_ev[irqev_pkg::EV_FATAL]) begin
            dead_cause <= '0;
        end else begin
            dead_cause <= dead_cause | (ctx_dead_in & ~dead_q); // [R12]
        end
    end

    // timer bit history; first sample after reset only primes it
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sec6_q <= 1'b0;
            cnt0_q <= 1'b0;
            timer_valid <= 1'b0;
        end else begin
            sec6_q <= cycle_timer_in.seconds[6]; // [R16]
            cnt0_q <= cycle_timer_in.count[0]; // [R17]
            timer_valid <= 1'b1;
        end
    end

    // overlong cycle timer, only while this node is timing root
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            overlong_run <= 1'b0;
            overlong_cnt <= '0;
        end else if (!link_ctrl[irqev_pkg::LC_ROOT_EN]) begin
            overlong_run <= 1'b0;
            overlong_cnt <= '0;
        end else if (tx_cs_rise) begin
            overlong_run <= 1'b1; // [R9]
            overlong_cnt <= '0;
        end else if (gap_rise || overlong_hit) begin
            overlong_run <= 1'b0;
        end else if (overlong_run) begin
            overlong_cnt <= overlong_cnt + 16'h0001;
        end
    end

    // missing cycle start tracking between synch points
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            seen_start <= 1'b0;
            sync_armed <= 1'b0;
            gap_seen <= 1'b0;
            loss_flagged <= 1'b0;
        end else if (synch) begin
            seen_start <= cs_any;
            sync_armed <= 1'b1;
            gap_seen <= 1'b0;
            loss_flagged <= 1'b0;
        end else begin
            if (cs_any) begin
                seen_start <= 1'b1;
            end
            // a second gap with no start between predicts a loss
            if (gap_rise) begin
                gap_seen <= 1'b1; // [R15]
            end
            if (lost_guess) begin
                loss_flagged <= 1'b1;
            end
        end
    end

    // read mux; summaries are computed live, never latched
    always_comb begin
        logic [31:0] summed;
        summed = ev;
        summed[irqev_pkg::EV_ISO_RX] =
            |(iso_rx_ctx_event_in & iso_rx_ctx_mask_in); // [R20]
        summed[irqev_pkg::EV_ISO_TX] =
            |(iso_tx_ctx_event_in & iso_tx_ctx_mask_in); // [R20]
        case (avs_address_in)
            irqev_pkg::OFS_CHAN_SET,
            irqev_pkg::OFS_CHAN_CLR: read_value = chan_enable;
            irqev_pkg::OFS_EV_SET,
            irqev_pkg::OFS_EV_CLR: read_value = summed & int_mask_in; // [R5]
            irqev_pkg::OFS_LINK_CTRL: read_value = link_ctrl;
            irqev_pkg::OFS_EV_RAW: read_value = summed;
            default: read_value = 32'h00000000;
        endcase
    end

    // one wait cycle per access; read data stand with waitrequest low
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
        end else if ((avs_read_in || avs_write_in) &&
                     avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= avs_read_in ? read_value : 32'h00000000;
        end else begin
            avs_waitrequest_out <= 1'b1;
        end
    end

    // registered copies of state for the outside
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rx_iso_accept_out <= 1'b0;
            iso_rx_chan_enable_out <= irqev_pkg::CHAN_RESET;
            int_event_out <= irqev_pkg::EV_RESET;
            root_timing_source_enable_out <= 1'b0;
        end else begin
            rx_iso_accept_out <= rx_iso_valid_in & ~rx_iso_chan_in[5] &
                chan_enable[rx_iso_chan_in[4:0]]; // [R1]
            iso_rx_chan_enable_out <= chan_enable;
            int_event_out <= ev;
            root_timing_source_enable_out <=
                link_ctrl[irqev_pkg::LC_ROOT_EN];
        end
    end

endmodule : irqev_core

// ==== verification/irqev_properties.sv ====
// port-level checks for the event and channel enable block
`timescale 1ns/1ps
module irqev_properties #(
    parameter int ISO_CTX = 4
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // host bus
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // event side
    input wire logic [31:0] int_mask_in,
    input wire logic phy_status_irq_in,
    input wire logic [ISO_CTX-1:0] iso_rx_ctx_event_in,
    input wire logic [ISO_CTX-1:0] iso_rx_ctx_mask_in,
    input wire logic [ISO_CTX-1:0] iso_tx_ctx_event_in,
    input wire logic [ISO_CTX-1:0] iso_tx_ctx_mask_in,
    // channel filter and state
    input wire logic rx_iso_valid_in,
    input wire logic [5:0] rx_iso_chan_in,
    input wire logic rx_iso_accept_out,
    input wire logic [31:0] iso_rx_chan_enable_out,
    input wire logic [31:0] int_event_out,
    input wire logic root_timing_source_enable_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // completed accesses; a write lands at this edge
    wire logic done = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    wire logic wr_done = done && avs_write_in;
    wire logic clr_done = wr_done && avs_address_in == 8'h84;
    wire logic set_done = wr_done && avs_address_in == 8'h80;
    // live summaries, never latched
    wire logic [31:0] summ = {24'h0,
        |(iso_rx_ctx_event_in & iso_rx_ctx_mask_in),
        |(iso_tx_ctx_event_in & iso_tx_ctx_mask_in), 6'h0};

    a_wait_short: assert property (
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low too long");
    a_req_answered: assert property (
        (avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request unanswered");
    a_reserved_zero: assert property (
        (int_event_out & ~irqev_pkg::EV_LATCH_MASK) == 32'h0)
        else $error("reserved bit latched");
    a_chan_accept: assert property (rx_iso_accept_out == (
        $past(rx_iso_valid_in) && $past(rx_iso_chan_in) < 6'd32 &&
        iso_rx_chan_enable_out[$past(rx_iso_chan_in[4:0])]))
        else $error("accept disagrees with enable");
    a_event_sticky: assert property (
        |($past(int_event_out) & ~int_event_out & ~32'h00010000)
        |-> $past(clr_done, 2)) else $error("event fell unasked");
    a_busrst_clears: assert property (
        $rose(int_event_out[17]) |-> !int_event_out[16])
        else $error("bit 16 kept on bus reset");
    a_overlong_root: assert property (
        $rose(int_event_out[25]) && !$past(set_done, 2)
        |-> !root_timing_source_enable_out)
        else $error("root enable kept");
    a_phy_sets: assert property (
        $rose(phy_status_irq_in) |-> ##2 int_event_out[19])
        else $error("bit 19 not set");
    a_event_read: assert property (
        done && avs_read_in && avs_address_in[7:3] == 5'h10 &&
        avs_address_in[1:0] == 2'h0 |-> avs_readdata_out ==
        ((int_event_out | $past(summ)) & $past(int_mask_in)))
        else $error("event read unmasked");
    a_chan_read: assert property (
        done && avs_read_in && avs_address_in[7:3] == 5'h0F &&
        avs_address_in[1:0] == 2'h0
        |-> avs_readdata_out == iso_rx_chan_enable_out)
        else $error("channel read wrong");

    c_read_done: cover property (done && avs_read_in);
    c_overlong: cover property ($rose(int_event_out[25]));
    c_accept: cover property (rx_iso_accept_out);
endmodule : irqev_properties

bind irqev_core irqev_properties #(.ISO_CTX(ISO_CTX)) i_irqev_properties (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .int_mask_in(int_mask_in),
    .phy_status_irq_in(phy_status_irq_in),
    .iso_rx_ctx_event_in(iso_rx_ctx_event_in),
    .iso_rx_ctx_mask_in(iso_rx_ctx_mask_in),
    .iso_tx_ctx_event_in(iso_tx_ctx_event_in),
    .iso_tx_ctx_mask_in(iso_tx_ctx_mask_in),
    .rx_iso_valid_in(rx_iso_valid_in), .rx_iso_chan_in(rx_iso_chan_in),
    .rx_iso_accept_out(rx_iso_accept_out),
    .iso_rx_chan_enable_out(iso_rx_chan_enable_out),
    .int_event_out(int_event_out),
    .root_timing_source_enable_out(root_timing_source_enable_out));

// ==== verification/tb.sv ====
// self-checking bench for the event and channel enable block
`timescale 1ns/1ps
module tb;
    // stimulus
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] mask = 32'hFFFFFFFF;
    logic [21:0] src = 22'h0;
    logic [3:0] rx_ev = 4'h0;
    logic [3:0] rx_mk = 4'h0;
    logic [3:0] tx_ev = 4'h0;
    logic [3:0] tx_mk = 4'h0;
    irqev_pkg::irqev_timer_t tmr = '0;
    irqev_pkg::irqev_timer_t stamp = '0;
    logic valid = 1'b0;
    logic [5:0] chan = 6'h0;
    // observed
    logic [31:0] rdata;
    logic [31:0] chan_en;
    logic [31:0] ev;
    logic waitreq;
    logic accept;
    logic root_en;
    int miscompares = 0;
    int num_checks = 0;

    // free-running clock
    always #12.5 ref_clk_in = ~ref_clk_in;

    // short overlong limit keeps the run brief
    irqev_core #(.OVERLONG_CYCLES(20)) i_irqev_core (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .int_mask_in(mask), .gp_input_a_in(src[0]), .gp_input_b_in(src[1]),
        .phys_reg_byte_arrived_in(src[2]), .phy_status_irq_in(src[3]),
        .serial_bus_reset_in(src[4]), .node_id_phase_done_in(src[5]),
        .ctx_event_in(src[9:6]), .misc_event_in(src[13:10]),
        .ctx_dead_in(src[17:14]), .cycle_timer_in(tmr), .rx_stamp_in(stamp),
        .rx_cycle_start_in(src[18]), .tx_cycle_start_in(src[19]),
        .subaction_gap_in(src[20]), .arb_reset_gap_in(src[21]),
        .iso_rx_ctx_event_in(rx_ev), .iso_rx_ctx_mask_in(rx_mk),
        .iso_tx_ctx_event_in(tx_ev), .iso_tx_ctx_mask_in(tx_mk),
        .rx_iso_valid_in(valid), .rx_iso_chan_in(chan),
        .rx_iso_accept_out(accept), .iso_rx_chan_enable_out(chan_en),
        .int_event_out(ev), .root_timing_source_enable_out(root_en));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : cyc

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do @(posedge ref_clk_in);
        while (waitreq !== 1'b0);
        q = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge ref_clk_in);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd

    // rising edge of one source
    task automatic pulse(input int i);
        src[i] <= 1'b1;
        cyc(4);
        src[i] <= 1'b0;
        cyc(1);
    endtask : pulse

    task automatic clr();
        wr(8'h84, 32'hFFFFFFFF);
        cyc(2);
    endtask : clr

    task automatic query(input logic [5:0] ch, input logic exp);
        valid <= 1'b1;
        chan <= ch;
        cyc(2);
        @(negedge ref_clk_in);
        chk({31'h0, accept}, {31'h0, exp});
        @(posedge ref_clk_in);
        valid <= 1'b0;
        cyc(1);
    endtask : query

    task automatic t_reset();
        chk(ev, 32'h0);
        rd(8'h78, irqev_pkg::CHAN_RESET);
        rd(8'h80, irqev_pkg::EV_RESET);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0);
        rd(8'h88, irqev_pkg::LC_RESET);
    endtask : t_reset

    // lane enables limit the set write to byte one
    task automatic t_chan();
        wr(8'h78, 32'h80000001);
        be <= 4'h2;
        wr(8'h78, 32'hFFFFFFFF);
        be <= 4'hF;
        rd(8'h7C, 32'h8000FF01);
        wr(8'h7C, 32'h0000FF01);
        wr(8'h78, 32'h0);
        rd(8'h78, 32'h80000000);
        query(6'd31, 1'b1);
        query(6'd0, 1'b0);
        query(6'd63, 1'b0);
    endtask : t_chan

    task automatic t_setclr();
        wr(8'h80, 32'hFFFEFFFF);
        cyc(2);
        chk(ev, 32'h47FA033F);
        mask <= 32'h0000FFFF;
        rx_ev <= 4'h4;
        rx_mk <= 4'h4;
        tx_ev <= 4'h2;
        tx_mk <= 4'h1;
        cyc(1);
        rd(8'h84, 32'h000003BF);
        wr(8'h84, 32'h0);
        cyc(2);
        chk(ev, 32'h47FA033F);
        mask <= 32'hFFFFFFFF;
        rx_ev <= 4'h0;
        tx_ev <= 4'h0;
        clr();
        chk(ev, 32'h0);
    endtask : t_setclr

    task automatic t_sources();
        int pos [14] = '{30, 30, 26, 19, 17, 16, 0, 1, 2, 3, 4, 5, 8, 9};
        pulse(0);
        chk(ev, 32'h0);
        wr(8'h88, 32'h00000003);
        for (int i = 0; i < 14; i++) begin
            pulse(i);
            chk(ev, 32'h1 << pos[i]);
            clr();
        end
        pulse(5);
        pulse(4);
        chk(ev, 32'h00020000);
        clr();
    endtask : t_sources

    // halted context's events held off
    task automatic t_fatal();
        pulse(14);
        chk(ev, 32'h01000000);
        pulse(6);
        pulse(7);
        chk(ev, 32'h01000002);
        clr();
        pulse(6);
        chk(ev, 32'h00000001);
        clr();
    endtask : t_fatal

    task automatic t_timer();
        tmr.count <= 13'h1;
        cyc(4);
        chk(ev & 32'h00100000, 32'h00100000);
        clr();
        stamp <= tmr;
        pulse(18);
        chk(ev & 32'h00800000, 32'h0);
        tmr.count <= 13'h2;
        cyc(4);
        chk(ev & 32'h00500000, 32'h00100000);
        tmr.count <= 13'h3;
        cyc(4);
        chk(ev & 32'h00400000, 32'h00400000);
        clr();
        stamp.count <= 13'h2;
        pulse(18);
        chk(ev & 32'h00800000, 32'h00800000);
        tmr.seconds <= 7'h01;
        cyc(4);
        chk(ev & 32'h00200000, 32'h0);
        tmr.seconds <= 7'h41;
        cyc(4);
        chk(ev & 32'h00200000, 32'h00200000);
        clr();
    endtask : t_timer

    task automatic t_overlong();
        wr(8'h88, 32'h00200003);
        rd(8'h88, 32'h00200003);
        pulse(19);
        pulse(20);
        cyc(30);
        chk(ev & 32'h02000000, 32'h0);
        chk({31'h0, root_en}, 32'h1);
        pulse(19);
        cyc(30);
        chk(ev & 32'h02000000, 32'h02000000);
        chk({31'h0, root_en}, 32'h0);
        rd(8'h88, 32'h00000003);
    endtask : t_overlong

    // main sequence
    initial begin
        cyc(2);
        sys_rst_in <= 1'b0;
        cyc(1);
        t_reset();
        t_chan();
        t_setclr();
        t_sources();
        t_fatal();
        t_timer();
        t_overlong();
        stop_test();
    end

    // watchdog
    initial begin
        cyc(20000);
        miscompares++;
        stop_test();
    end
endmodule : tb
